// ### pin_mux_pkg.sv
/*
 * constants for the display output pin multiplexer: register map,
 * control field positions, reset values, strap bit positions, panel types.
 * assumes a 32-bit apb register bus and 16 memory-data strap pins.
 */
`default_nettype none
package pin_mux_pkg;
    // register byte addresses
    localparam logic [7:0] CTRL_ADDR   = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h04;

    // control register field positions
    localparam int CTRL_TYPE_LSB  = 0;
    localparam int CTRL_WIDTH_LSB = 2;
    localparam int CTRL_UPPER_BIT = 4;
    localparam int CTRL_PIXB_BIT  = 5;
    localparam int CTRL_EXPB_BIT  = 6;
    localparam int CTRL_MEMEN_BIT = 7;
    localparam int CTRL_DRIVE_BIT = 8;
    localparam int CTRL_POWER_BIT = 9;

    // status register field positions
    localparam int STAT_STRAP_LSB = 0;
    localparam int STAT_CLKA_BIT  = 16;
    localparam int STAT_CLKB_BIT  = 17;

    // control reset values
    localparam logic [1:0] TYPE_RESET  = 2'h0;
    localparam logic [1:0] WIDTH_RESET = 2'h3;
    localparam logic       POWER_RESET = 1'b1;
    localparam logic       MEMEN_RESET = 1'b1;

    // memory-data strap positions that steer pin functions
    localparam int STRAP_CTL_BIT  = 12;
    localparam int STRAP_DATA_BIT = 13;
    localparam int STRAP_PWR_BIT  = 14;

    localparam int STRAP_W = 16;
    localparam int DATA_W  = 16;

    typedef enum logic [1:0] {
        PANEL_TFT     = 2'b00,
        PANEL_FORMAT1 = 2'b01,
        PANEL_PASSIVE = 2'b11,
        PANEL_OTHER   = 2'b10
    } panel_type_e;

    typedef enum logic [1:0] {
        WIDTH_4  = 2'b00,
        WIDTH_8  = 2'b01,
        WIDTH_12 = 2'b11,
        WIDTH_16 = 2'b10
    } panel_width_e;
endpackage : pin_mux_pkg
`default_nettype wire

// ### edge_sync.sv
/*
 * three-flop synchroniser for pins from outside the clock domain;
 * a level counts once the second and third flops agree.
 * assumes the pin changes no faster than a few clock periods.
 */
`timescale 1ns/10ps
`default_nettype none
module edge_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_clk,
    input  wire logic             i_rstn,
    input  wire logic [WIDTH-1:0] i_pin,
    output var  logic [WIDTH-1:0] o_level,
    output var  logic [WIDTH-1:0] o_rise
);
    logic [WIDTH-1:0] ff1_reg;
    logic [WIDTH-1:0] ff2_reg;
    logic [WIDTH-1:0] ff3_reg;
    logic [WIDTH-1:0] level_reg;
    logic [WIDTH-1:0] rise_reg;

    // ff1 feeds only ff2; agreement of ff2/ff3 filters a glitching pin
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            ff1_reg   <= '0;
            ff2_reg   <= '0;
            ff3_reg   <= '0;
            level_reg <= '0;
            rise_reg  <= '0;
        end
        else
        begin
            ff1_reg <= i_pin;
            ff2_reg <= ff1_reg;
            ff3_reg <= ff2_reg;
            for (int i = 0; i < WIDTH; i++)
            begin
                if (ff2_reg[i] == ff3_reg[i])
                begin
                    level_reg[i] <= ff3_reg[i];
                end
                rise_reg[i] <= (ff2_reg[i] == ff3_reg[i]) && ff3_reg[i] && !level_reg[i];
            end
        end
    end

    assign o_level = level_reg;
    assign o_rise  = rise_reg;
endmodule : edge_sync
`default_nettype wire

// ### display_output_pin_mux.sv
/*
 * display output pin multiplexer: panel data, panel timing, crt retrace,
 * multi-purpose display pin, expansion port pins, clock source selection.
 * assumes an apb master on i_clk and panel timing from logic on i_clk.
 */
// How it works
// - panel data bits beyond the selected panel width are driven low
// - upper data byte can carry expansion port functions when enabled
// - tft panel: multi-purpose pin is the display enable
// - passive format 1 panel: multi-purpose pin is the second shift clock
// - any other panel: multi-purpose pin is the backplane bias
// - data bit 9 low in reset, or floating when strapped as port control
// - data bits 13:10 low in reset, or floating when strapped as port data
// - multi-purpose pin low in reset, high when strapped as port power
// - horizontal and vertical retrace outputs, both low during reset
// - clock input a may feed pixel, memory and expansion clocks
// - clock input b may feed pixel or expansion clock, never memory
// - memory-data straps are caught at reset release and select pins
`timescale 1ns/10ps
`default_nettype none
module display_output_pin_mux (
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output var  logic [31:0] o_prdata,
    output var  logic        o_pready,
    output var  logic        o_pslverr,
    input  wire logic [15:0] i_memory_data_straps,
    input  wire logic        i_clock_input_a,
    input  wire logic        i_clock_input_b,
    input  wire logic [15:0] i_panel_data,
    input  wire logic        i_panel_frame_pulse,
    input  wire logic        i_panel_line_pulse,
    input  wire logic        i_panel_shift_clock,
    input  wire logic        i_second_shift_clock,
    input  wire logic        i_display_enable,
    input  wire logic        i_backplane_bias,
    input  wire logic        i_horizontal_retrace,
    input  wire logic        i_vertical_retrace,
    input  wire logic [7:0]  i_expansion_byte,
    input  wire logic        i_expansion_port_control,
    input  wire logic [3:0]  i_expansion_port_data_out,
    input  wire logic [3:0]  i_expansion_port_data_pin,
    output var  logic [15:0] o_panel_data_bus,
    output var  logic        o_bit9_oen,
    output var  logic [3:0]  o_expansion_port_data_oen,
    output var  logic [3:0]  o_expansion_port_data,
    output var  logic        o_panel_frame_pulse,
    output var  logic        o_panel_line_pulse,
    output var  logic        o_panel_shift_clock,
    output var  logic        o_display_enable_multi_pin,
    output var  logic        o_horizontal_retrace,
    output var  logic        o_vertical_retrace,
    output var  logic        o_pixel_clk_tick,
    output var  logic        o_memory_clk_tick,
    output var  logic        o_expansion_clk_tick
);
    typedef struct packed {
        logic [1:0]  type_reg;
        logic [1:0]  width_reg;
        logic        upper_reg;
        logic        pixb_reg;
        logic        expb_reg;
        logic        memen_reg;
        logic        drive_reg;
        logic        power_reg;
        logic [31:0] prdata_reg;
        logic        slverr_reg;
        logic [15:0] data_reg;
        logic        bit9_oen_reg;
        logic [3:0]  port_oen_reg;
        logic        multi_reg;
        logic        frame_reg;
        logic        line_reg;
        logic        shift_reg;
        logic        hretr_reg;
        logic        vretr_reg;
        logic        pix_tick_reg;
        logic        mem_tick_reg;
        logic        exp_tick_reg;
    } state_s;

    logic [1:0]  rst_pipe_reg;
    logic        rst_n;
    logic [15:0] strap_reg;
    state_s      st_reg;
    state_s      st_next;
    logic [1:0]  clk_level;
    logic [1:0]  clk_rise;
    logic [3:0]  port_level;
    logic        strap_ctl;
    logic        strap_data;
    logic        strap_pwr;
    logic [15:0] width_mask;

    // reset leaves through two flops so every flop sees a clean release
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            rst_pipe_reg <= 2'h0;
        end
        else
        begin
            rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe_reg[1];

    // straps follow the pins while reset holds and freeze at its release;
    // no async reset here, since a flop under reset may only take a constant
    always_ff @(posedge i_clk)
    begin
        if (!rst_n)
        begin
            strap_reg <= i_memory_data_straps;
        end
    end
    assign strap_ctl  = strap_reg[pin_mux_pkg::STRAP_CTL_BIT];
    assign strap_data = strap_reg[pin_mux_pkg::STRAP_DATA_BIT];
    assign strap_pwr  = strap_reg[pin_mux_pkg::STRAP_PWR_BIT];

    edge_sync #(
        .WIDTH (2)
    ) u_clk_sync (
        .i_clk   (i_clk),
        .i_rstn  (rst_n),
        .i_pin   ({i_clock_input_b, i_clock_input_a}),
        .o_level (clk_level),
        .o_rise  (clk_rise)
    );

    edge_sync #(
        .WIDTH (4)
    ) u_port_sync (
        .i_clk   (i_clk),
        .i_rstn  (rst_n),
        .i_pin   (i_expansion_port_data_pin),
        .o_level (port_level),
        .o_rise  ()
    );

    always_comb
    begin
        case (st_reg.width_reg)
            pin_mux_pkg::WIDTH_4:  width_mask = 16'h000F;
            pin_mux_pkg::WIDTH_8:  width_mask = 16'h00FF;
            pin_mux_pkg::WIDTH_12: width_mask = 16'h0FFF;
            default:               width_mask = 16'hFFFF;
        endcase
    end

    always_comb
    begin
        st_next = st_reg;

        // apb: read data prepared in the setup cycle, so pready needs no wait
        if (i_psel && !i_penable)
        begin
            st_next.prdata_reg = 32'h0000_0000;
            st_next.slverr_reg = 1'b0;
            if (i_paddr == pin_mux_pkg::CTRL_ADDR)
            begin
                st_next.prdata_reg[pin_mux_pkg::CTRL_TYPE_LSB +: 2]  = st_reg.type_reg;
                st_next.prdata_reg[pin_mux_pkg::CTRL_WIDTH_LSB +: 2] = st_reg.width_reg;
                st_next.prdata_reg[pin_mux_pkg::CTRL_UPPER_BIT] = st_reg.upper_reg;
                st_next.prdata_reg[pin_mux_pkg::CTRL_PIXB_BIT]  = st_reg.pixb_reg;
                st_next.prdata_reg[pin_mux_pkg::CTRL_EXPB_BIT]  = st_reg.expb_reg;
                st_next.prdata_reg[pin_mux_pkg::CTRL_MEMEN_BIT] = st_reg.memen_reg;
                st_next.prdata_reg[pin_mux_pkg::CTRL_DRIVE_BIT] = st_reg.drive_reg;
                st_next.prdata_reg[pin_mux_pkg::CTRL_POWER_BIT] = st_reg.power_reg;
            end
            else if (i_paddr == pin_mux_pkg::STATUS_ADDR)
            begin
                st_next.prdata_reg[pin_mux_pkg::STAT_STRAP_LSB +: 16] = strap_reg;
                st_next.prdata_reg[pin_mux_pkg::STAT_CLKA_BIT] = clk_level[0];
                st_next.prdata_reg[pin_mux_pkg::STAT_CLKB_BIT] = clk_level[1];
            end
            else
            begin
                st_next.slverr_reg = 1'b1;
            end
        end

        // status is read-only; a write there is answered without effect
        if (i_psel && i_penable && i_pwrite && i_paddr == pin_mux_pkg::CTRL_ADDR)
        begin
            st_next.type_reg  = i_pwdata[pin_mux_pkg::CTRL_TYPE_LSB +: 2];
            st_next.width_reg = i_pwdata[pin_mux_pkg::CTRL_WIDTH_LSB +: 2];
            st_next.upper_reg = i_pwdata[pin_mux_pkg::CTRL_UPPER_BIT];
            st_next.pixb_reg  = i_pwdata[pin_mux_pkg::CTRL_PIXB_BIT];
            st_next.expb_reg  = i_pwdata[pin_mux_pkg::CTRL_EXPB_BIT];
            st_next.memen_reg = i_pwdata[pin_mux_pkg::CTRL_MEMEN_BIT];
            st_next.drive_reg = i_pwdata[pin_mux_pkg::CTRL_DRIVE_BIT];
            st_next.power_reg = i_pwdata[pin_mux_pkg::CTRL_POWER_BIT];
        end

        st_next.data_reg = i_panel_data & width_mask;
        if (st_reg.upper_reg)
        begin
            st_next.data_reg[15:8] = i_expansion_byte;
        end
        st_next.bit9_oen_reg = 1'b0;
        if (strap_ctl)
        begin
            st_next.data_reg[9] = i_expansion_port_control;
        end
        st_next.port_oen_reg = 4'h0;
        if (strap_data)
        begin
            st_next.data_reg[13:10] = i_expansion_port_data_out;
            st_next.port_oen_reg = {4{!st_reg.drive_reg}};
        end

        if (strap_pwr)
        begin
            st_next.multi_reg = st_reg.power_reg;
        end
        else
        begin
            case (st_reg.type_reg)
                pin_mux_pkg::PANEL_TFT:
                    st_next.multi_reg = i_display_enable;
                pin_mux_pkg::PANEL_FORMAT1:
                    st_next.multi_reg = i_second_shift_clock;
                default:
                    st_next.multi_reg = i_backplane_bias;
            endcase
        end

        st_next.frame_reg = i_panel_frame_pulse;
        st_next.line_reg  = i_panel_line_pulse;
        st_next.shift_reg = i_panel_shift_clock;
        st_next.hretr_reg = i_horizontal_retrace;
        st_next.vretr_reg = i_vertical_retrace;

        // clock sources: memory clock has only input a, by construction
        st_next.pix_tick_reg = st_reg.pixb_reg ? clk_rise[1] : clk_rise[0];
        st_next.exp_tick_reg = st_reg.expb_reg ? clk_rise[1] : clk_rise[0];
        st_next.mem_tick_reg = st_reg.memen_reg && clk_rise[0];
    end

    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg           <= '0;
            st_reg.type_reg  <= pin_mux_pkg::TYPE_RESET;
            st_reg.width_reg <= pin_mux_pkg::WIDTH_RESET;
            st_reg.power_reg <= pin_mux_pkg::POWER_RESET;
            st_reg.memen_reg <= pin_mux_pkg::MEMEN_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign o_pready  = 1'b1;
    assign o_prdata  = st_reg.prdata_reg;
    assign o_pslverr = st_reg.slverr_reg;

    // during reset the strapped roles decide float or drive; the output flops
    // hold zero, so driven data pins read low and the multi-purpose pin shows the power strap
    assign o_panel_data_bus = st_reg.data_reg;
    assign o_bit9_oen = rst_n ? st_reg.bit9_oen_reg : strap_ctl;
    assign o_expansion_port_data_oen =
        rst_n ? st_reg.port_oen_reg : {4{strap_data}};
    assign o_expansion_port_data = port_level;
    assign o_display_enable_multi_pin = rst_n ? st_reg.multi_reg : strap_pwr;
    assign o_panel_frame_pulse  = st_reg.frame_reg;
    assign o_panel_line_pulse   = st_reg.line_reg;
    assign o_panel_shift_clock  = st_reg.shift_reg;
    assign o_horizontal_retrace = st_reg.hretr_reg;
    assign o_vertical_retrace   = st_reg.vretr_reg;
    assign o_pixel_clk_tick     = st_reg.pix_tick_reg;
    assign o_memory_clk_tick    = st_reg.mem_tick_reg;
    assign o_expansion_clk_tick = st_reg.exp_tick_reg;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);

    sequence s_ready;
        rst_n && $past(rst_n);
    endsequence

    sequence s_narrow;
        st_reg.width_reg == pin_mux_pkg::WIDTH_4 && !st_reg.upper_reg;
    endsequence

    unused_low_a: assert property (
        s_ready ##0 s_narrow |=> o_panel_data_bus[8:4] == 5'h00)
        else $error("unused panel data bits not low");

    upper_byte_a: assert property (
        rst_n && st_reg.upper_reg |=>
            o_panel_data_bus[15:14] == $past(i_expansion_byte[7:6]))
        else $error("upper byte not carrying expansion data");

    tft_enable_a: assert property (
        s_ready ##0 (st_reg.type_reg == pin_mux_pkg::PANEL_TFT && !strap_pwr)
            |=> o_display_enable_multi_pin == $past(i_display_enable))
        else $error("multi pin not display enable for tft");

    format1_shift_a: assert property (
        s_ready ##0 (st_reg.type_reg == pin_mux_pkg::PANEL_FORMAT1 && !strap_pwr)
            |=> o_display_enable_multi_pin == $past(i_second_shift_clock))
        else $error("multi pin not second shift clock");

    bias_pin_a: assert property (
        s_ready ##0 (st_reg.type_reg[1] && !strap_pwr)
            |=> o_display_enable_multi_pin == $past(i_backplane_bias))
        else $error("multi pin not backplane bias");

    bit9_reset_a: assert property (
        !rst_n |-> !o_panel_data_bus[9]
            && (o_bit9_oen == strap_reg[pin_mux_pkg::STRAP_CTL_BIT]))
        else $error("data bit 9 wrong during reset");

    port_reset_a: assert property (
        !rst_n && !strap_data |-> o_panel_data_bus[13:10] == 4'h0
            && o_expansion_port_data_oen == 4'h0)
        else $error("data bits 13:10 wrong during reset");

    power_reset_a: assert property (
        !rst_n |-> o_display_enable_multi_pin == strap_reg[pin_mux_pkg::STRAP_PWR_BIT])
        else $error("multi pin wrong during reset");

    retrace_low_a: assert property (
        !rst_n |-> !o_horizontal_retrace && !o_vertical_retrace)
        else $error("retrace not low during reset");

    pixel_src_a: assert property (
        s_ready ##0 (!st_reg.pixb_reg && clk_rise[0]) |=> o_pixel_clk_tick)
        else $error("pixel tick missing from clock input a");

    mem_src_a: assert property (
        rst_n && o_memory_clk_tick |-> $past(clk_rise[0]))
        else $error("memory tick not from clock input a");

    strap_hold_a: assert property (
        s_ready |-> $stable(strap_reg))
        else $error("straps changed after reset release");
endmodule : display_output_pin_mux
`default_nettype wire

// ### panel_model.sv
/*
 * far-side model: a panel that latches the data bus on each rising shift
 * clock, plus an expansion peripheral that drives data lines 13:10.
 * assumes the bench resolves each line from the device's enables alone.
 */
`timescale 1ns/10ps
`default_nettype none
module panel_model #(
    parameter logic [3:0] DRIVE = 4'h6
) (
    input  wire logic        i_shift,
    input  wire logic [15:0] i_data,
    output var  logic [15:0] o_word,
    output var  logic [3:0]  o_pins
);
    // the panel sees data only on the shift edge, as a real panel would
    always_ff @(posedge i_shift)
    begin
        o_word <= i_data;
    end

    // peripheral value; it only reaches the wire where the device lets go
    always_comb
    begin
        o_pins = DRIVE;
    end
endmodule : panel_model
`default_nettype wire

// ### display_output_pin_mux_test.sv
/*
 * self-checking bench for the display output pin multiplexer.
 * assumes an apb slave on the same clock and the panel model on the far side.
 */
`timescale 1ns/10ps
`default_nettype none
module display_output_pin_mux_test;
    localparam logic [3:0] FAR    = 4'h6;
    localparam logic [7:0] WCODES = {pin_mux_pkg::WIDTH_16, pin_mux_pkg::WIDTH_12,
                                     pin_mux_pkg::WIDTH_8, pin_mux_pkg::WIDTH_4};
    logic        clk, rstn, psel, penable, pwrite, pready, pslverr, err, ca, cb;
    logic        fp, lp, shift, sshift, de, bias, hr, vr, pctl, b9oen, fr_o, ln_o;
    logic        sh_o, multi, hr_o, vr_o, pix_t, mem_t, exp_t, run_a, run_b;
    logic [7:0]  paddr, xbyte;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] straps, pdata, bus, seen_word;
    logic [3:0]  xout, xin, doen, xdata, far_pins;
    int          n_fail = 0, checks = 0, cyc = 0, n_pix = 0, n_mem = 0, n_exp = 0;

    // released lines carry the peripheral, driven lines the device
    assign xin = (doen & far_pins) | (~doen & bus[13:10]);

    display_output_pin_mux dut (
        .i_clk(clk), .i_resetn(rstn), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_memory_data_straps(straps),
        .i_clock_input_a(ca), .i_clock_input_b(cb), .i_panel_data(pdata),
        .i_panel_frame_pulse(fp), .i_panel_line_pulse(lp),
        .i_panel_shift_clock(shift), .i_second_shift_clock(sshift),
        .i_display_enable(de), .i_backplane_bias(bias), .i_horizontal_retrace(hr),
        .i_vertical_retrace(vr), .i_expansion_byte(xbyte),
        .i_expansion_port_control(pctl), .i_expansion_port_data_out(xout),
        .i_expansion_port_data_pin(xin), .o_panel_data_bus(bus), .o_bit9_oen(b9oen),
        .o_expansion_port_data_oen(doen), .o_expansion_port_data(xdata),
        .o_panel_frame_pulse(fr_o), .o_panel_line_pulse(ln_o),
        .o_panel_shift_clock(sh_o), .o_display_enable_multi_pin(multi),
        .o_horizontal_retrace(hr_o), .o_vertical_retrace(vr_o),
        .o_pixel_clk_tick(pix_t), .o_memory_clk_tick(mem_t), .o_expansion_clk_tick(exp_t)
    );

    panel_model #(.DRIVE(FAR)) far_side (
        .i_shift(sh_o), .i_data(bus), .o_word(seen_word), .o_pins(far_pins)
    );

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // link clocks stand still low between bursts; odd offsets keep phases apart
    initial
    begin
        ca = 1'b0;
        #3;
        forever #32 ca = run_a ? ~ca : 1'b0;
    end

    initial
    begin
        cb = 1'b0;
        #17;
        forever #32 cb = run_b ? ~cb : 1'b0;
    end

    // ticks are counted mid-cycle, away from the edge that launches them
    always @(negedge clk)
    begin
        cyc++;
        n_pix += int'(pix_t);
        n_mem += int'(mem_t);
        n_exp += int'(exp_t);
        if (cyc == 20000)
        begin
            n_fail++;
            print_verdict();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic settle();
        repeat (6) @(posedge clk);
        #1;
    endtask : settle

    // one apb transfer; pready is awaited, only the run's timeout ends a wait
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
        begin
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic do_reset(input logic [15:0] s);
        @(posedge clk);
        rstn <= 1'b0;
        straps <= s;
        repeat (10) @(posedge clk);
        #1;
        check(bus, 32'h0000_0000);
        check({hr_o, vr_o, fr_o, ln_o, sh_o, pix_t, mem_t, exp_t}, 8'h00);
        check(b9oen, s[pin_mux_pkg::STRAP_CTL_BIT]);
        check(doen, {4{s[pin_mux_pkg::STRAP_DATA_BIT]}});
        check(multi, s[pin_mux_pkg::STRAP_PWR_BIT]);
        @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        straps <= ~s;
        apb(1'b0, pin_mux_pkg::STATUS_ADDR, 32'h0000_0000);
        check(rd[15:0], s);
    endtask : do_reset

    task automatic clock_case(input logic [31:0] c, input logic a, input logic b,
                              input logic [2:0] e);
        int p0;
        int m0;
        int e0;
        apb(1'b1, pin_mux_pkg::CTRL_ADDR, c);
        p0 = n_pix;
        m0 = n_mem;
        e0 = n_exp;
        run_a = a;
        run_b = b;
        repeat (400) @(posedge clk);
        run_a = 1'b0;
        run_b = 1'b0;
        repeat (20) @(posedge clk);
        check({n_pix > p0, n_mem > m0, n_exp > e0}, e);
    endtask : clock_case

    task automatic print_verdict();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
        begin
            $display("*** PASS ***");
        end
        else
        begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict

    initial
    begin
        {rstn, psel, penable, pwrite, fp, lp, shift, sshift} = '0;
        {de, bias, hr, vr, pctl, run_a, run_b} = '0;
        {paddr, xbyte, pwdata, straps, pdata, xout} = '0;
        do_reset(16'h0000);
        apb(1'b0, pin_mux_pkg::CTRL_ADDR, 32'h0000_0000);
        check(rd, 32'h0000_028C);
        apb(1'b1, pin_mux_pkg::STATUS_ADDR, 32'hFFFF_FFFF);
        apb(1'b0, pin_mux_pkg::STATUS_ADDR, 32'h0000_0000);
        check(rd[15:0], 16'h0000);
        apb(1'b1, 8'h08, 32'hFFFF_FFFF);
        check(err, 1'b1);
        apb(1'b0, 8'h08, 32'h0000_0000);
        check(err, 1'b1);
        check(rd, 32'h0000_0000);
        apb(1'b0, pin_mux_pkg::CTRL_ADDR, 32'h0000_0000);
        check(rd, 32'h0000_028C);
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, pin_mux_pkg::CTRL_ADDR, 32'h0000_0280 | (32'(WCODES[2*i +: 2]) << 2));
            @(posedge clk);
            pdata <= 16'hFFFF;
            settle();
            check(bus, 16'hFFFF >> (12 - 4 * i));
        end
        @(posedge clk);
        pdata <= 16'h5A3C;
        settle();
        @(posedge clk);
        shift <= 1'b1;
        settle();
        check(seen_word, 16'h5A3C);
        apb(1'b1, pin_mux_pkg::CTRL_ADDR, 32'h0000_0298);
        @(posedge clk);
        xbyte <= 8'hA5;
        pdata <= 16'h1234;
        settle();
        check(bus, 16'hA534);
        for (int t = 0; t < 4; t++)
        begin
            apb(1'b1, pin_mux_pkg::CTRL_ADDR, 32'h0000_0288 | t);
            for (int j = 0; j < 3; j++)
            begin
                @(posedge clk);
                {de, sshift, bias} <= 3'b100 >> j;
                settle();
                check(multi, (t == 0 && j == 0) || (t == 1 && j == 1) || (t > 1 && j == 2));
            end
        end
        for (int k = 0; k < 2; k++)
        begin
            @(posedge clk);
            {hr, vr, fp, lp} <= k ? 4'h6 : 4'h9;
            settle();
            check({hr_o, vr_o, fr_o, ln_o}, k ? 4'h6 : 4'h9);
        end
        clock_case(32'h0000_0288, 1'b1, 1'b0, 3'b111);
        clock_case(32'h0000_02E8, 1'b1, 1'b0, 3'b010);
        clock_case(32'h0000_02E8, 1'b0, 1'b1, 3'b101);
        clock_case(32'h0000_0288, 1'b0, 1'b1, 3'b000);
        clock_case(32'h0000_0208, 1'b1, 1'b0, 3'b101);
        // sources left high so the reset levels are not just idle zeros
        @(posedge clk);
        {hr, vr} <= 2'b11;
        do_reset(16'h7000);
        @(posedge clk);
        pctl <= 1'b1;
        xout <= 4'h9;
        settle();
        check(b9oen, 1'b0);
        check(bus[9], 1'b1);
        check(doen, 4'hF);
        check(xdata, FAR);
        check(multi, pin_mux_pkg::POWER_RESET);
        apb(1'b1, pin_mux_pkg::CTRL_ADDR, 32'h0000_0188);
        settle();
        check(doen, 4'h0);
        check(bus[13:10], 4'h9);
        check(multi, 1'b0);
        print_verdict();
    end
endmodule : display_output_pin_mux_test
`default_nettype wire
